// >>> logic/epl_map.vh
`ifndef EPL_MAP_VH
`define EPL_MAP_VH
// ----------------------------------------
// Preload image layout
// ----------------------------------------
`define EPL_WORD_COUNT 5'h15
`define EPL_LAST_WORD 5'h14
`define EPL_W_FLAG 5'h01
`define EPL_W_HSDEV 5'h02
`define EPL_W_HSCFG 5'h03
`define EPL_W_NODE0 5'h04
`define EPL_W_NODE1 5'h05
`define EPL_W_NODE2 5'h06
`define EPL_W_STR0 5'h08
`define EPL_W_PHYOFS 5'h0f
`define EPL_W_MAXPKT 5'h10
`define EPL_W_PHYSEL 5'h11
`define EPL_W_WATER 5'h12
`define EPL_W_FSDEV 5'h13
`define EPL_W_FSCFG 5'h14
// ----------------------------------------
// Flag word bit positions
// ----------------------------------------
`define EPL_F_SELFPWR 0
`define EPL_F_WAKEUP 2
`define EPL_F_NOCHIRP 4
`define EPL_F_SWRST 5
`define EPL_F_STRIP 6
`define EPL_F_APPEND 7
`define EPL_F_CAPTURE 8
`define EPL_F_DEBUG 9
// ----------------------------------------
// Transceiver constants
// ----------------------------------------
`define EPL_TYPE_ETH 3'b000
`define EPL_TYPE_NONE 3'b111
`define EPL_EMB_ADDR 5'h10
`define EPL_BCAST_ADDR 5'h00
`define EPL_REG_CTRL 5'h00
`define EPL_PDN_DATA 16'h0800
`define EPL_WM_SHIFT 8
`define EPL_LANG_ID 16'h0904
`define EPL_CAPS 16'h11ac
// ----------------------------------------
// Reset values before commit
// ----------------------------------------
`define EPL_DEF_MAXFRAME 16'h0600
`define EPL_DEF_PHYSEL 16'he010
`define EPL_DEF_WATER 16'h0000
// ----------------------------------------
// Serial frames and timing
// ----------------------------------------
`define EPL_MD_PRE 32'hffffffff
`define EPL_MD_ST 2'b01
`define EPL_MD_OP_WR 2'b01
`define EPL_MD_OP_RD 2'b10
`define EPL_MD_TA 2'b10
`define EPL_EE_READ 3'b110
`define EPL_MD_LEN 7'd64
`define EPL_MD_RD_DRV 7'd46
`define EPL_EE_DRV 7'd11
`define EPL_EE_LEN 7'd27
`define EPL_CLK_NS 5
`define EPL_HALF_NS 250
`define EPL_HALF_CYC ((`EPL_HALF_NS + `EPL_CLK_NS - 1) / `EPL_CLK_NS)
// ----------------------------------------
// Register port offsets
// ----------------------------------------
`define EPL_A_STATUS 8'h20
`define EPL_A_RSTCTL 8'h21
`define EPL_A_CAPS 8'h22
`define EPL_A_LANG 8'h23
`endif

// >>> logic/epl_preloader.v
`timescale 1ns/1ps
`include "epl_map.vh"
module epl_preloader #(
   parameter HALF_CYC = `EPL_HALF_CYC
) (
   input wire clk_sys,
   input wire nrst,
   input wire [7:0] regAddr,
   input wire [15:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [15:0] regRdData,
   output reg eeCs,
   output reg eeSk,
   output reg eeDi,
   input wire eeDo,
   output reg mdc,
   output reg mdioOut,
   output reg mdioOeN,
   input wire mdioIn,
   input wire embMdioIn,
   output reg embPhySel,
   input wire usbBusReset,
   input wire intPktReq,
   output reg [31:0] intReport,
   output reg intReportValid,
   input wire fullDuplex,
   input wire [14:0] rxFreeBytes,
   output reg pauseReq,
   input wire [3:0] descSel,
   output reg [7:0] descLen,
   output reg [7:0] descOffset,
   input wire [15:0] strLangId,
   output reg strLangOk,
   output reg loadDone,
   output reg descReady,
   output reg selfPowered,
   output reg remoteWakeupCapable,
   output reg chirpKDisable,
   output reg rxStripFcs,
   output reg txAppendFcs,
   output reg captureEffectMode,
   output reg debugPortEnable,
   output reg transceiverResetOutN,
   output reg [47:0] stationMac,
   output reg [15:0] maxFrameSize,
   output reg [7:0] pauseHighMark,
   output reg [7:0] pauseLowMark
);
   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   localparam [3:0] ST_LOAD = 4'b0001;
   localparam [3:0] ST_PDN = 4'b0010;
   localparam [3:0] ST_RUN = 4'b0100;
   localparam [3:0] ST_INT = 4'b1000;

   reg [15:0] romWord [0:20]; // Raw image, valid once committed
   reg [3:0] state_reg; // Sequencer state
   reg [4:0] wordIdx_reg; // Word being fetched
   reg [1:0] step_reg; // Step within power-down or status read
   reg waiting_reg; // Frame issued, awaiting done
   reg intPend_reg; // Interrupt packet request latched
   reg [15:0] intVal1_reg; // First status word
   reg [1:0] eeDoSync_reg; // Pin synchroniser
   reg [1:0] mdioSync_reg; // Pin synchroniser
   reg transceiverResetLevel_reg; // Software level for reset pin
   reg transceiverResetToggleEn_reg; // Reset pin control enable
   // Serial engine
   reg [63:0] shReg; // Outgoing bits, MSB first
   reg [6:0] bitCnt; // Current bit
   reg [6:0] drvLen; // Bits driven by us
   reg [6:0] totLen; // Bits in frame
   reg engActive;
   reg engPhase; // 0 low half, 1 high half
   reg engDone; // One-cycle completion pulse
   reg engIsEe; // Frame targets the EEPROM
   reg [15:0] inShift; // Last 16 sampled bits
   reg [15:0] divCnt; // Half-period divider
   reg engStart; // Start pulse from sequencer
   reg [63:0] engVec;
   reg [6:0] engDrv;
   reg [6:0] engTot;
   reg engEe;

   wire [15:0] flagW = loadDone ? romWord[`EPL_W_FLAG] : 16'h0000;
   wire [15:0] physelW = loadDone ? romWord[`EPL_W_PHYSEL] : `EPL_DEF_PHYSEL;
   wire [15:0] phyofsW = loadDone ? romWord[`EPL_W_PHYOFS] : 16'h0000;
   wire [4:0] primAddr = physelW[4:0];
   wire [2:0] primType = physelW[7:5];
   wire [4:0] secAddr = physelW[12:8];
   wire [2:0] secType = physelW[15:13];
   wire divTick = (divCnt == HALF_CYC[15:0] - 16'h0001);
   wire engIn = engIsEe ? eeDoSync_reg[1] : (embPhySel ? embMdioIn : mdioSync_reg[1]);
   wire [6:0] nextBit = bitCnt + 7'd1;

   // ----------------------------------------
   // Descriptor word lookup
   // ----------------------------------------
   function [4:0] descWord;
      input [3:0] sel;
      begin
         case (sel)
            4'h0: descWord = `EPL_W_HSDEV;
            4'h1: descWord = `EPL_W_HSCFG;
            4'h9: descWord = `EPL_W_FSDEV;
            4'ha: descWord = `EPL_W_FSCFG;
            default: descWord = (sel > 4'h8) ? `EPL_W_HSDEV : `EPL_W_STR0 + {1'b0, sel} - 5'h02;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Frame builder for the sequencer
   // ----------------------------------------
   always @* begin
      engStart = 1'b0;
      engVec = 64'h0;
      engDrv = `EPL_MD_LEN;
      engTot = `EPL_MD_LEN;
      engEe = 1'b0;
      if (!waiting_reg) begin
         case (state_reg)
            ST_LOAD: begin
               // Word read: start, opcode, address, then 16 data bits
               engStart = 1'b1;
               engVec = {`EPL_EE_READ, 3'b000, wordIdx_reg, 53'h0};
               engDrv = `EPL_EE_DRV;
               engTot = `EPL_EE_LEN;
               engEe = 1'b1;
            end
            ST_PDN: begin
               // Skip slots marked unsupported
               engStart = (step_reg == 2'd0) || (step_reg == 2'd1 && primType != `EPL_TYPE_NONE)
                  || (step_reg == 2'd2 && secType != `EPL_TYPE_NONE);
               engVec = {`EPL_MD_PRE, `EPL_MD_ST, `EPL_MD_OP_WR,
                  (step_reg == 2'd0) ? `EPL_BCAST_ADDR : (step_reg == 2'd1) ? primAddr : secAddr,
                  `EPL_REG_CTRL, `EPL_MD_TA, `EPL_PDN_DATA};
            end
            ST_INT: begin
               engStart = 1'b1;
               engVec = {`EPL_MD_PRE, `EPL_MD_ST, `EPL_MD_OP_RD, primAddr,
                  (step_reg == 2'd0) ? phyofsW[12:8] : phyofsW[4:0], 2'b00, 16'h0};
               engDrv = `EPL_MD_RD_DRV;
            end
            default: engStart = 1'b0;
         endcase
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         eeDoSync_reg <= 2'b00;
         mdioSync_reg <= 2'b11;
      end else begin
         eeDoSync_reg <= {eeDoSync_reg[0], eeDo};
         mdioSync_reg <= {mdioSync_reg[0], mdioIn};
      end
   end

   // ----------------------------------------
   // Serial engine, shared by EEPROM and management frames
   // ----------------------------------------
   // Data changes on the falling edge and input is sampled just before it,
   // which leaves a full half period for the far side to settle.
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         shReg <= 64'h0;
         bitCnt <= 7'd0;
         drvLen <= 7'd0;
         totLen <= 7'd0;
         engActive <= 1'b0;
         engPhase <= 1'b0;
         engDone <= 1'b0;
         engIsEe <= 1'b0;
         inShift <= 16'h0;
         divCnt <= 16'h0;
         eeCs <= 1'b0;
         eeSk <= 1'b0;
         eeDi <= 1'b0;
         mdc <= 1'b0;
         mdioOut <= 1'b1;
         mdioOeN <= 1'b1;
         embPhySel <= 1'b0;
      end else begin
         engDone <= 1'b0;
         divCnt <= divTick ? 16'h0 : divCnt + 16'h0001;
         if (engStart && !engActive) begin
            // Load frame and present first bit
            shReg <= engVec;
            bitCnt <= 7'd0;
            drvLen <= engDrv;
            totLen <= engTot;
            engActive <= 1'b1;
            engPhase <= 1'b0;
            engIsEe <= engEe;
            divCnt <= 16'h0;
            eeCs <= engEe;
            eeDi <= engEe & engVec[63];
            mdioOut <= engEe | engVec[63];
            mdioOeN <= engEe;
            embPhySel <= !engEe && (engVec[27:23] == `EPL_EMB_ADDR);
         end else if (engActive && divTick) begin
            if (!engPhase) begin
               // Rising edge of the serial clock
               engPhase <= 1'b1;
               eeSk <= engIsEe;
               mdc <= !engIsEe;
            end else begin
               // Sample, fall, advance
               engPhase <= 1'b0;
               eeSk <= 1'b0;
               mdc <= 1'b0;
               inShift <= {inShift[14:0], engIn};
               shReg <= {shReg[62:0], 1'b0};
               bitCnt <= nextBit;
               eeDi <= engIsEe & shReg[62] & (nextBit < drvLen);
               mdioOut <= engIsEe | shReg[62] | (nextBit >= drvLen);
               mdioOeN <= engIsEe | (nextBit >= drvLen);
               if (nextBit == totLen) begin
                  engActive <= 1'b0;
                  engDone <= 1'b1;
                  eeCs <= 1'b0;
                  mdioOeN <= 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Sequencer: load, power down, then serve status reads
   // ----------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_LOAD;
         wordIdx_reg <= 5'h00;
         step_reg <= 2'd0;
         waiting_reg <= 1'b0;
         intPend_reg <= 1'b0;
         intVal1_reg <= 16'h0;
         intReport <= 32'h0;
         intReportValid <= 1'b0;
         loadDone <= 1'b0;
         descReady <= 1'b0;
      end else begin
         intReportValid <= 1'b0;
         // New request beats the clear on service
         if (intPktReq) begin
            intPend_reg <= 1'b1;
         end else if (state_reg == ST_RUN && intPend_reg) begin
            intPend_reg <= 1'b0;
         end
         if (engStart) begin
            waiting_reg <= 1'b1;
         end
         case (state_reg)
            ST_LOAD: begin
               if (engDone) begin
                  waiting_reg <= 1'b0;
                  wordIdx_reg <= wordIdx_reg + 5'h01;
                  if (wordIdx_reg == `EPL_LAST_WORD) begin
                     loadDone <= 1'b1;
                     state_reg <= ST_PDN;
                     step_reg <= 2'd0;
                  end
               end
            end
            ST_PDN: begin
               if (engDone || (!waiting_reg && !engStart)) begin
                  waiting_reg <= 1'b0;
                  step_reg <= step_reg + 2'd1;
                  if (step_reg == 2'd2) begin
                     state_reg <= ST_RUN;
                     descReady <= 1'b1;
                     step_reg <= 2'd0;
                  end
               end
            end
            ST_RUN: begin
               if (intPend_reg) begin
                  state_reg <= ST_INT;
                  step_reg <= 2'd0;
               end
            end
            ST_INT: begin
               if (engDone) begin
                  waiting_reg <= 1'b0;
                  if (step_reg == 2'd0) begin
                     intVal1_reg <= inShift;
                     step_reg <= 2'd1;
                  end else begin
                     // Bytes 5..8: low byte first for each value
                     intReport <= {inShift[15:8], inShift[7:0],
                        intVal1_reg[15:8], intVal1_reg[7:0]};
                     intReportValid <= 1'b1;
                     state_reg <= ST_RUN;
                  end
               end
            end
            default: state_reg <= ST_LOAD;
         endcase
      end
   end

   // ----------------------------------------
   // Image capture; no reset, gated by loadDone
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (state_reg == ST_LOAD && engDone) begin
         romWord[wordIdx_reg] <= inShift;
      end
   end

   // ----------------------------------------
   // Committed configuration outputs
   // ----------------------------------------
   // Reserved flag bits reach no configuration output, only the register port readback.
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         selfPowered <= 1'b0;
         remoteWakeupCapable <= 1'b0;
         chirpKDisable <= 1'b0;
         rxStripFcs <= 1'b0;
         txAppendFcs <= 1'b0;
         captureEffectMode <= 1'b0;
         debugPortEnable <= 1'b0;
         stationMac <= 48'h0;
         maxFrameSize <= `EPL_DEF_MAXFRAME;
         pauseHighMark <= 8'h00;
         pauseLowMark <= 8'h00;
         descLen <= 8'h00;
         descOffset <= 8'h00;
         strLangOk <= 1'b0;
      end else begin
         selfPowered <= flagW[`EPL_F_SELFPWR];
         remoteWakeupCapable <= flagW[`EPL_F_WAKEUP];
         chirpKDisable <= flagW[`EPL_F_NOCHIRP];
         rxStripFcs <= flagW[`EPL_F_STRIP];
         txAppendFcs <= flagW[`EPL_F_APPEND];
         captureEffectMode <= flagW[`EPL_F_CAPTURE];
         debugPortEnable <= flagW[`EPL_F_DEBUG];
         if (loadDone) begin
            // Node byte 0 is the first octet on the wire
            stationMac <= {romWord[`EPL_W_NODE0][7:0], romWord[`EPL_W_NODE0][15:8],
               romWord[`EPL_W_NODE1][7:0], romWord[`EPL_W_NODE1][15:8],
               romWord[`EPL_W_NODE2][7:0], romWord[`EPL_W_NODE2][15:8]};
            maxFrameSize <= romWord[`EPL_W_MAXPKT];
            pauseHighMark <= romWord[`EPL_W_WATER][15:8];
            pauseLowMark <= romWord[`EPL_W_WATER][7:0];
            // Length in high byte, word offset in low byte
            descLen <= romWord[descWord(descSel)][15:8];
            descOffset <= romWord[descWord(descSel)][7:0];
         end
         strLangOk <= (strLangId == `EPL_LANG_ID);
      end
   end

   // ----------------------------------------
   // Pause request and transceiver reset pin
   // ----------------------------------------
   // Free space is in 256-byte units, compared with the marks.
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pauseReq <= 1'b0;
         transceiverResetOutN <= 1'b1;
      end else begin
         if (!fullDuplex || !loadDone) begin
            pauseReq <= 1'b0;
         end else if ({1'b0, rxFreeBytes[14:`EPL_WM_SHIFT]} <= pauseHighMark) begin
            pauseReq <= 1'b1;
         end else if ({1'b0, rxFreeBytes[14:`EPL_WM_SHIFT]} >= pauseLowMark) begin
            pauseReq <= 1'b0;
         end
         if (!transceiverResetToggleEn_reg) begin
            transceiverResetOutN <= 1'b1;
         end else if (flagW[`EPL_F_SWRST]) begin
            transceiverResetOutN <= transceiverResetLevel_reg;
         end else begin
            transceiverResetOutN <= !usbBusReset;
         end
      end
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         regRdData <= 16'h0;
         transceiverResetLevel_reg <= 1'b1;
         transceiverResetToggleEn_reg <= 1'b0;
      end else begin
         if (regWr && regAddr == `EPL_A_RSTCTL) begin
            transceiverResetLevel_reg <= regWrData[0];
            transceiverResetToggleEn_reg <= regWrData[1];
         end
         regRdData <= 16'h0;
         if (regRd) begin
            if (regAddr <= {3'b000, `EPL_LAST_WORD}) begin
               regRdData <= loadDone ? romWord[regAddr[4:0]] : 16'h0000;
            end else if (regAddr == `EPL_A_STATUS) begin
               regRdData <= {13'h0, descReady, loadDone, !descReady};
            end else if (regAddr == `EPL_A_RSTCTL) begin
               regRdData <= {14'h0, transceiverResetToggleEn_reg, transceiverResetLevel_reg};
            end else if (regAddr == `EPL_A_CAPS) begin
               regRdData <= `EPL_CAPS;
            end else if (regAddr == `EPL_A_LANG) begin
               regRdData <= `EPL_LANG_ID;
            end
         end
      end
   end
endmodule

// >>> test/epl_preloader_properties.sv
`timescale 1ns/1ps
module epl_preloader_properties (
   input wire clk_sys,
   input wire nrst,
   input wire regRd,
   input wire [7:0] regAddr,
   input wire [15:0] regRdData,
   input wire [15:0] strLangId,
   input wire strLangOk,
   input wire eeCs,
   input wire mdioOeN,
   input wire loadDone,
   input wire descReady,
   input wire selfPowered,
   input wire [47:0] stationMac,
   input wire fullDuplex,
   input wire pauseReq,
   input wire intReportValid
);
   // ------
   // One clock domain, one reset
   // ------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   property p_autoStart; $rose(nrst) |-> ##[0:3] eeCs; endproperty
   a_autoStart: assert property (p_autoStart) else $error("no fetch after reset");
   property p_cfgHold; !loadDone |-> stationMac == 48'h0 && !selfPowered; endproperty
   a_cfgHold: assert property (p_cfgHold) else $error("config before commit");
   property p_doneHolds; loadDone |=> loadDone; endproperty
   a_doneHolds: assert property (p_doneHolds) else $error("load done dropped");
   // Power-down needs the loaded addresses, so no management frame may start early
   property p_mdioQuiet; !loadDone |-> mdioOeN; endproperty
   a_mdioQuiet: assert property (p_mdioQuiet) else $error("mgmt drive before load");
   property p_readyAfter; descReady |-> loadDone; endproperty
   a_readyAfter: assert property (p_readyAfter) else $error("ready before load");
   property p_langOk; $past(nrst) |-> strLangOk == ($past(strLangId) == 16'h0904); endproperty
   a_langOk: assert property (p_langOk) else $error("language match wrong");
   property p_langRead; regRd && regAddr == 8'h23 |=> regRdData == 16'h0904; endproperty
   a_langRead: assert property (p_langRead) else $error("language read wrong");
   property p_capsRead; regRd && regAddr == 8'h22 |=> regRdData == 16'h11ac; endproperty
   a_capsRead: assert property (p_capsRead) else $error("caps read wrong");
   property p_pauseOff; !fullDuplex |=> !pauseReq; endproperty
   a_pauseOff: assert property (p_pauseOff) else $error("pause in half duplex");
   property p_intPulse; intReportValid |=> !intReportValid; endproperty
   a_intPulse: assert property (p_intPulse) else $error("report valid too long");
endmodule

bind epl_preloader epl_preloader_properties u_chk (.clk_sys(clk_sys), .nrst(nrst),
   .regRd(regRd), .regAddr(regAddr), .regRdData(regRdData), .strLangId(strLangId),
   .strLangOk(strLangOk), .eeCs(eeCs), .mdioOeN(mdioOeN), .loadDone(loadDone),
   .descReady(descReady), .selfPowered(selfPowered), .stationMac(stationMac),
   .fullDuplex(fullDuplex), .pauseReq(pauseReq), .intReportValid(intReportValid));

// >>> test/epl_eeprom_model.sv
`timescale 1ns/1ps
module epl_eeprom_model #(
   parameter [335:0] IMG = 336'h0 // Image, word 0 in the low bits
) (
   input wire eeCs,
   input wire eeSk,
   input wire eeDi,
   output wire eeDo
);
   integer cnt; // Clock count inside a frame
   reg [10:0] cmd; // Start, opcode, address
   reg doReg; // Last driven data bit
   // Serves the image words; bad opcode or address gets a pattern
   wire [15:0] word = (cmd[10:8] == 3'b110 && cmd[7:0] < 8'd21) ?
      IMG[cmd[7:0]*16 +: 16] : 16'h5a5a;
   initial begin
      cnt = 0;
      cmd = 11'h0;
      doReg = 1'b0;
   end
   // ------
   // Frame decode
   // ------
   always @(posedge eeCs) begin
      cnt = 0;
   end
   always @(posedge eeSk) begin
      if (eeCs) begin
         cnt = cnt + 1;
         if (cnt <= 11) cmd = {cmd[9:0], eeDi};
         if (cnt == 11) doReg = 1'b0; // Dummy zero
         else if (cnt > 11 && cnt <= 27) doReg = word[27 - cnt];
      end
   end
   // Unselected output floats; show the inverse, not a stale bit
   assign eeDo = eeCs ? doReg : ~doReg;
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ------
   // Image: flags carry reserved bits, frame size 1500
   // ------
   localparam [335:0] IMG = {16'h2000, 16'h1200, 16'h0408, 16'he001, 16'h05dc, 16'h0102,
      16'h0e7e, 16'h0d70, 16'h0c60, 16'h0b50, 16'h0a40, 16'h0930, 16'h0820, 16'h0409,
      16'hab89, 16'h6745, 16'h2301, 16'h2040, 16'h1234, 16'hfdb3, 16'h0015};
   reg clk_sys, nrst, regWr, regRd, usbBusReset, intPktReq, fullDuplex;
   reg [7:0] regAddr;
   reg [15:0] regWrData, strLangId, f;
   reg [14:0] rxFreeBytes;
   reg [3:0] descSel;
   wire eeCs, eeSk, eeDi, eeDo, mdc, mdioOut, mdioOeN, embPhySel, intReportValid, strLangOk;
   wire loadDone, descReady, selfPowered, remoteWakeupCapable, chirpKDisable, rxStripFcs;
   wire txAppendFcs, captureEffectMode, debugPortEnable, transceiverResetOutN, pauseReq;
   wire [15:0] regRdData, maxFrameSize;
   wire [31:0] intReport;
   wire [7:0] descLen, descOffset, pauseHighMark, pauseLowMark;
   wire [47:0] stationMac;
   // Management monitor: last 64 bits seen and count of clock edges
   reg [63:0] mdFrm = 64'h0;
   integer mdBits = 0;
   // Released line answers zeros in the first read, ones after it
   wire mdioIn = mdioOeN ? (mdBits > 192) : mdioOut;
   wire embMdioIn = mdioIn;
   integer mismatches = 0, samples_checked = 0, i, k;

   epl_preloader #(.HALF_CYC(6)) dut (.clk_sys, .nrst, .regAddr, .regWrData, .regWr, .regRd,
      .regRdData, .eeCs, .eeSk, .eeDi, .eeDo, .mdc, .mdioOut, .mdioOeN, .mdioIn, .embMdioIn,
      .embPhySel, .usbBusReset, .intPktReq, .intReport, .intReportValid, .fullDuplex,
      .rxFreeBytes, .pauseReq, .descSel, .descLen, .descOffset, .strLangId, .strLangOk,
      .loadDone, .descReady, .selfPowered, .remoteWakeupCapable, .chirpKDisable, .rxStripFcs,
      .txAppendFcs, .captureEffectMode, .debugPortEnable, .transceiverResetOutN, .stationMac,
      .maxFrameSize, .pauseHighMark, .pauseLowMark);
   epl_eeprom_model #(.IMG(IMG)) ee (.eeCs, .eeSk, .eeDi, .eeDo);
   // Capture the management line on each rising management clock
   always @(posedge mdc) begin
      mdFrm <= {mdFrm[62:0], mdioIn};
      mdBits <= mdBits + 1;
   end

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // ------
   // Shared tasks
   // ------
   task chk(input [47:0] got, input [47:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task rd(input [7:0] a, input [15:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 chk(regRdData, e);
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task final_report;
      $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Watchdog: whole run is near 10k cycles
   initial begin
      #300000;
      mismatches++;
      final_report;
   end
   // ------
   // Main sequence
   // ------
   initial begin
      {nrst, regWr, regRd, usbBusReset, intPktReq, fullDuplex} = 6'h0;
      {regAddr, regWrData, descSel} = 28'h0;
      strLangId = 16'h0409;
      rxFreeBytes = 15'h7fff;
      f = IMG[31:16];
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      for (i = 0; i < 20000 && loadDone !== 1'b1; i++) tick(1);
      chk(loadDone, 1);
      for (i = 0; i < 21; i++) rd(i, IMG[i*16 +: 16]);
      chk({selfPowered, remoteWakeupCapable, chirpKDisable, rxStripFcs, txAppendFcs,
         captureEffectMode, debugPortEnable}, {f[0], f[2], f[4], f[6], f[7], f[8], f[9]});
      chk(stationMac, 48'h0123456789ab);
      chk({maxFrameSize, pauseHighMark, pauseLowMark}, {IMG[271:256], IMG[303:288]});
      for (i = 0; i < 5000 && descReady !== 1'b1; i++) tick(1);
      chk(descReady, 1);
      chk(mdBits, 128);
      chk(mdFrm[47:0], 48'hffff50820800);
      rd(8'h20, 16'h0006);
      rd(8'h22, 16'h11ac);
      rd(8'h23, 16'h0904);
      rd(8'h30, 16'h0000);
      @(posedge clk_sys) strLangId <= 16'h0904;
      tick(2);
      chk(strLangOk, 1);
      // Descriptor selects 0 to 10, word 02h on
      for (k = 0; k < 11; k++) begin
         @(posedge clk_sys) descSel <= k;
         tick(2);
         i = k < 2 ? k + 2 : (k < 9 ? k + 6 : k + 10);
         chk({descLen, descOffset}, IMG[i*16 +: 16]);
      end
      // Flag bit 5 set: level bit wins, bus reset ignored
      @(posedge clk_sys) usbBusReset <= 1'b1;
      wr(8'h21, 16'h0002);
      tick(2);
      chk(transceiverResetOutN, 0);
      wr(8'h21, 16'h0003);
      tick(2);
      chk(transceiverResetOutN, 1);
      rd(8'h21, 16'h0003);
      // Marks: high 4, low 8 units of 256 free bytes
      @(posedge clk_sys) fullDuplex <= 1'b1;
      rxFreeBytes <= 15'h04ff;
      tick(3);
      chk(pauseReq, 1);
      @(posedge clk_sys) rxFreeBytes <= 15'h07ff;
      tick(3);
      chk(pauseReq, 1);
      @(posedge clk_sys) rxFreeBytes <= 15'h0800;
      tick(3);
      chk(pauseReq, 0);
      @(posedge clk_sys) rxFreeBytes <= 15'h0100;
      fullDuplex <= 1'b0;
      tick(3);
      chk(pauseReq, 0);
      @(posedge clk_sys) intPktReq <= 1'b1;
      @(posedge clk_sys) intPktReq <= 1'b0;
      for (i = 0; i < 5000 && intReportValid !== 1'b1; i++) tick(1);
      chk(intReportValid, 1);
      chk(intReport, 32'hffff0000);
      chk(mdFrm[47:0], 48'hffff608bffff);
      chk(mdBits, 256);
      final_report;
   end
endmodule
